/* rmoi_regs.svh */
`ifndef RMOI_REGS_SVH
`define RMOI_REGS_SVH

// Mode register addresses seen on the command bus
`define RMOI_ADDR_BANK_MASK  6'h10
`define RMOI_ADDR_SEG_MASK   6'h11
`define RMOI_ADDR_OSC_LOW    6'h12
`define RMOI_ADDR_OSC_HIGH   6'h13
`define RMOI_ADDR_UP_INVERT  6'h14

// Reset values
`define RMOI_MASK_RESET      8'h00
`define RMOI_INVERT_RESET    8'h55
`define RMOI_READ_IDLE       8'h00

// Oscillator count layout
`define RMOI_OSC_WIDTH       16
`define RMOI_OSC_LOW_LSB     0
`define RMOI_OSC_HIGH_LSB    8

// Top row bit of the segment field for each density group
`define RMOI_SEG_TOP_2G      13
`define RMOI_SEG_TOP_4G      14
`define RMOI_SEG_TOP_8G      15
`define RMOI_SEG_TOP_16G     16

`endif

/* rmoi_pkg.sv */
package rmoi_pkg;

  // Density shared by both channels, selects which row bits form the segment
  typedef enum logic [2:0] {
    RMOI_DEN_2G,
    RMOI_DEN_3G,
    RMOI_DEN_4G,
    RMOI_DEN_6G,
    RMOI_DEN_8G,
    RMOI_DEN_12G,
    RMOI_DEN_16G
  } rmoi_density_type;

  // One mode register command from the controller
  typedef struct packed {
    logic       write;      // Mode register write
    logic       read;       // Mode register read
    logic       channel;    // Target channel
    logic [5:0] addr;       // Mode register address
    logic [7:0] data;       // Write operand
  } rmoi_cmd_type;

  // One refresh query from the refresh engine
  typedef struct packed {
    logic        valid;     // Query present
    logic        channel;   // Channel being refreshed
    logic [2:0]  bank;      // Bank being refreshed
    logic [16:0] row;       // Row being refreshed
  } rmoi_refresh_type;

  // Read calibration drive for the upper byte
  typedef struct packed {
    logic [7:0] dq;         // Pattern on the eight upper lanes
    logic       dmi;        // Pattern on the upper mask lane
  } rmoi_cal_lane_type;

endpackage

/* rmoi_osc_counter.sv */
`include "rmoi_regs.svh"

module rmoi_osc_counter #(
  parameter int COUNT_WIDTH = `RMOI_OSC_WIDTH
) (
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic                   osc_pin,
  input  wire logic                   osc_start,
  input  wire logic                   osc_stop,
  output logic      [COUNT_WIDTH-1:0] count_r,
  output logic                        running_r
);

  // Register reads split the count into two bytes
  initial begin
    if (COUNT_WIDTH != `RMOI_OSC_WIDTH) $error("rmoi_osc_counter: width must match two bytes");
  end

  logic sync1_r;   // First stage, read only by sync2_r
  logic sync2_r;   // Second stage, safe to use
  logic prev_r;    // Delayed copy for edge detection
  wire  rise_edge; // Rising edge of the oscillator input
  wire  at_max;    // Count saturated

  assign rise_edge = sync2_r & ~prev_r;
  assign at_max    = &count_r;

  // Two-flop synchroniser plus edge history
  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end else begin
      sync1_r <= osc_pin;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // Run flag, start wins over stop
  always_ff @(posedge clock) begin
    if (rst) running_r <= 1'b0;
    else if (osc_start) running_r <= 1'b1;
    else if (osc_stop) running_r <= 1'b0;
  end

  // Count edges; a start clears the old result
  // Saturates rather than wraps so a long run never reads as short
  always_ff @(posedge clock) begin
    if (rst) count_r <= '0;
    else if (osc_start) count_r <= '0;
    else if (running_r && rise_edge && !at_max) count_r <= count_r + 1'b1;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_start;
    osc_start;
  endsequence

  sequence s_cleared;
    count_r == '0;
  endsequence

  chk_start_clears: assert property (s_start |=> s_cleared)
    else $error("count not cleared after start");
  chk_idle_holds: assert property (!running_r && !osc_start |=> $stable(count_r))
    else $error("count moved while stopped");
  chk_count_step: assert property (!osc_start && !rst |=> (count_r == $past(count_r)) || (count_r == $past(count_r) + 1'b1))
    else $error("count stepped by more than one");

endmodule

/* rmoi_mode_regs.sv */
`include "rmoi_regs.svh"

module rmoi_mode_regs #(
  parameter int CHANNELS = 2
) (
  input  wire logic                      clock,
  input  wire logic                      rst,
  input  wire rmoi_pkg::rmoi_cmd_type    cmd,
  input  wire rmoi_pkg::rmoi_density_type density,
  input  wire rmoi_pkg::rmoi_refresh_type refresh_req,
  input  wire logic                      osc_pin,
  input  wire logic                      osc_start,
  input  wire logic                      osc_stop,
  input  wire logic                      cal_active,
  input  wire logic                      cal_pattern_bit,
  input  wire logic                      dbi_enable,
  output logic                     [7:0] read_data_r,
  output logic                           read_valid_r,
  output logic                           refresh_skip_r,
  output logic                           refresh_ack_r,
  output logic [CHANNELS-1:0]      [7:0] bank_mask_r,
  output logic [CHANNELS-1:0]      [7:0] seg_mask_r,
  output rmoi_pkg::rmoi_cal_lane_type    cal_lane_r,
  output logic                           dbi_active_r,
  output logic                           osc_running_r
);

  // Channel select is a single bit in the command
  initial begin
    if (CHANNELS < 1 || CHANNELS > 2) $error("rmoi_mode_regs: one or two channels only");
  end

  // Segment number from the row, by density
  function automatic logic [2:0] seg_of(input logic [16:0] row, input rmoi_pkg::rmoi_density_type den);
    logic [2:0] seg;
    seg = '0;
    unique case (den)
      rmoi_pkg::RMOI_DEN_2G:  seg = row[`RMOI_SEG_TOP_2G  -: 3];
      rmoi_pkg::RMOI_DEN_3G,
      rmoi_pkg::RMOI_DEN_4G:  seg = row[`RMOI_SEG_TOP_4G  -: 3];
      rmoi_pkg::RMOI_DEN_6G,
      rmoi_pkg::RMOI_DEN_8G:  seg = row[`RMOI_SEG_TOP_8G  -: 3];
      rmoi_pkg::RMOI_DEN_12G,
      rmoi_pkg::RMOI_DEN_16G: seg = row[`RMOI_SEG_TOP_16G -: 3];
      default:                seg = row[`RMOI_SEG_TOP_16G -: 3];
    endcase
    return seg;
  endfunction

  // Address decode, shared by writes and reads
  function automatic logic hit(input rmoi_pkg::rmoi_cmd_type c, input logic [5:0] a);
    return c.addr == a;
  endfunction

  logic [7:0]                  up_invert_r;   // Upper-byte invert mask
  logic [`RMOI_OSC_WIDTH-1:0]  osc_count;     // Live oscillator count
  logic                        osc_run;       // Oscillator counter running
  wire                         wr_bank;       // Write to bank mask
  wire                         wr_seg;        // Write to segment mask
  wire                         wr_inv;        // Write to invert mask
  wire  [7:0]                  rd_mux;        // Read data selection
  wire  [2:0]                  req_seg;       // Segment of the queried row
  wire                         ch_sel;        // Channel that a write targets
  wire                         req_ch;        // Channel that a query targets
  wire                         skip_nxt;      // Refresh must be skipped
  wire  [7:0]                  pattern_byte;  // Pattern copied onto eight lanes
  wire  [7:0]                  dq_nxt;        // Upper lane drive

  // Osc count registers have no write strobe at all
  assign wr_bank = cmd.write & hit(cmd, `RMOI_ADDR_BANK_MASK);
  assign wr_seg  = cmd.write & hit(cmd, `RMOI_ADDR_SEG_MASK);
  assign wr_inv  = cmd.write & hit(cmd, `RMOI_ADDR_UP_INVERT);
  assign ch_sel  = (CHANNELS > 1) ? cmd.channel : 1'b0;
  assign req_ch  = (CHANNELS > 1) ? refresh_req.channel : 1'b0;

  // Only the count bytes read back; write-only registers read as idle value
  assign rd_mux =
    hit(cmd, `RMOI_ADDR_OSC_LOW)  ? osc_count[`RMOI_OSC_LOW_LSB  +: 8] :
    hit(cmd, `RMOI_ADDR_OSC_HIGH) ? osc_count[`RMOI_OSC_HIGH_LSB +: 8] :
    `RMOI_READ_IDLE;

  // Segment lookup by the density's row bits
  assign req_seg  = seg_of(refresh_req.row, density);
  // Either mask of the target channel stops the refresh
  assign skip_nxt = bank_mask_r[req_ch][refresh_req.bank] | seg_mask_r[req_ch][req_seg];

  // Each lane takes the pattern, flipped where its invert bit is set
  assign pattern_byte = {8{cal_pattern_bit}};
  assign dq_nxt       = pattern_byte ^ up_invert_r;

  // Per-channel refresh masks
  generate
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
      // Bank mask, cleared at reset
      always_ff @(posedge clock) begin
        if (rst) bank_mask_r[ch] <= `RMOI_MASK_RESET;
        else if (wr_bank && ch_sel == 1'(ch)) bank_mask_r[ch] <= cmd.data;
      end
      // Segment mask, cleared at reset; top bits trusted to the controller
      always_ff @(posedge clock) begin
        if (rst) seg_mask_r[ch] <= `RMOI_MASK_RESET;
        else if (wr_seg && ch_sel == 1'(ch)) seg_mask_r[ch] <= cmd.data;
      end
    end
  endgenerate

  // Upper-byte invert mask, alternate lanes inverted at reset
  always_ff @(posedge clock) begin
    if (rst) up_invert_r <= `RMOI_INVERT_RESET;
    else if (wr_inv) up_invert_r <= cmd.data;
  end

  // Read answer one cycle after the command
  always_ff @(posedge clock) begin
    if (rst) begin
      read_data_r  <= `RMOI_READ_IDLE;
      read_valid_r <= 1'b0;
    end else begin
      read_data_r  <= cmd.read ? rd_mux : `RMOI_READ_IDLE;
      read_valid_r <= cmd.read;
    end
  end

  // Refresh verdict one cycle after the query
  always_ff @(posedge clock) begin
    if (rst) begin
      refresh_skip_r <= 1'b0;
      refresh_ack_r  <= 1'b0;
    end else begin
      refresh_skip_r <= refresh_req.valid & skip_nxt;
      refresh_ack_r  <= refresh_req.valid;
    end
  end

  // Calibration drive; mask lane never inverted, inversion off in calibration
  always_ff @(posedge clock) begin
    if (rst) begin
      cal_lane_r   <= '0;
      dbi_active_r <= 1'b0;
    end else begin
      cal_lane_r.dq  <= cal_active ? dq_nxt : '0;
      cal_lane_r.dmi <= cal_active & cal_pattern_bit;
      dbi_active_r   <= dbi_enable & ~cal_active;
    end
  end

  // Oscillator measurement; a start clears both bytes
  rmoi_osc_counter #(
    .COUNT_WIDTH (`RMOI_OSC_WIDTH)
  ) u_osc (
    .clock     (clock),
    .rst       (rst),
    .osc_pin   (osc_pin),
    .osc_start (osc_start),
    .osc_stop  (osc_stop),
    .count_r   (osc_count),
    .running_r (osc_run)
  );

  // Running flag straight from a flop
  always_ff @(posedge clock) begin
    if (rst) osc_running_r <= 1'b0;
    else osc_running_r <= osc_run;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_write_bank0;
    cmd.write && cmd.addr == `RMOI_ADDR_BANK_MASK && !cmd.channel;
  endsequence

  sequence s_read_osc_low;
    cmd.read && cmd.addr == `RMOI_ADDR_OSC_LOW && !cmd.write;
  endsequence

  sequence s_read_osc_high;
    cmd.read && cmd.addr == `RMOI_ADDR_OSC_HIGH && !cmd.write;
  endsequence

  chk_bank_write: assert property (s_write_bank0 |=> bank_mask_r[0] == $past(cmd.data))
    else $error("bank mask did not take the write");
  chk_chan_apart: assert property (cmd.write && cmd.channel && CHANNELS > 1 |=> $stable(bank_mask_r[0]) && $stable(seg_mask_r[0]))
    else $error("other channel mask changed");
  chk_seg_write: assert property (cmd.write && cmd.addr == `RMOI_ADDR_SEG_MASK |=> seg_mask_r[$past(ch_sel)] == $past(cmd.data))
    else $error("segment mask did not take the write");
  chk_skip_seg: assert property (refresh_req.valid && seg_mask_r[req_ch][req_seg] |=> refresh_skip_r && refresh_ack_r)
    else $error("masked segment was refreshed");
  chk_read_low: assert property (s_read_osc_low |=> read_valid_r && read_data_r == $past(osc_count[7:0]))
    else $error("low count byte wrong");
  chk_read_high: assert property (s_read_osc_high |=> read_valid_r && read_data_r == $past(osc_count[15:8]))
    else $error("high count byte wrong");
  chk_invert_lane: assert property (cal_active |=> cal_lane_r.dq == ($past(pattern_byte) ^ $past(up_invert_r)))
    else $error("upper lane inversion wrong");
  chk_invert_reset: assert property ($fell(rst) |-> up_invert_r == `RMOI_INVERT_RESET)
    else $error("invert mask not at reset value");
  chk_dmi_true: assert property (cal_active |=> cal_lane_r.dmi == $past(cal_pattern_bit))
    else $error("mask lane inverted");
  chk_no_dbi_cal: assert property (cal_active |=> !dbi_active_r)
    else $error("bus inversion during calibration");
  chk_ro_ignored: assert property (cmd.write && (cmd.addr == `RMOI_ADDR_OSC_LOW || cmd.addr == `RMOI_ADDR_OSC_HIGH) |=> $stable(up_invert_r) && $stable(bank_mask_r) && $stable(seg_mask_r))
    else $error("write to count register had effect");

endmodule

/* rmoi_ctrl_model.sv */
// Controller model: issues mode register commands and oscillator commands
module rmoi_ctrl_model (
  input  wire logic                       clock,
  input  wire rmoi_pkg::rmoi_density_type density,
  input  wire logic [7:0]                 read_data_r,
  input  wire logic                       read_valid_r,
  output rmoi_pkg::rmoi_cmd_type          cmd,
  output logic                            osc_start,
  output logic                            osc_stop
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle bus until a task drives it
  initial begin
    cmd = '0;
    osc_start = 1'b0;
    osc_stop = 1'b0;
  end

  // One write, held for one edge
  task automatic mrw(input logic ch, input logic [5:0] addr, input logic [7:0] data);
    logic [7:0] op;
    op = data;
    // Odd densities lack the top two segments, so keep those bits low
    if (addr == 6'h11 && density inside {rmoi_pkg::RMOI_DEN_3G, rmoi_pkg::RMOI_DEN_6G, rmoi_pkg::RMOI_DEN_12G}) begin
      op[7:6] = 2'h0;
    end
    @(posedge clock);
    cmd <= '{write: 1'b1, read: 1'b0, channel: ch, addr: addr, data: op};
    @(posedge clock);
    cmd <= '0;
    // Step past the edge so callers see the updated register
    #1;
  endtask

  // One read; answer sampled once it has settled
  task automatic mrr(input logic ch, input logic [5:0] addr, output logic [7:0] data, output logic ok);
    @(posedge clock);
    cmd <= '{write: 1'b0, read: 1'b1, channel: ch, addr: addr, data: 8'h00};
    @(posedge clock);
    cmd <= '0;
    #1;
    data = read_data_r;
    ok = read_valid_r;
  endtask

  // Full count from both bytes, high byte first
  task automatic read_count(output logic [15:0] count);
    logic [7:0] lo;
    logic [7:0] hi;
    logic       ok;
    mrr(1'b0, 6'h13, hi, ok);
    mrr(1'b0, 6'h12, lo, ok);
    count = {hi, lo};
  endtask

  // Start or stop pulse of one cycle
  task automatic osc_cmd(input logic start);
    @(posedge clock);
    if (start) begin
      osc_start <= 1'b1;
    end else begin
      osc_stop <= 1'b1;
    end
    @(posedge clock);
    osc_start <= 1'b0;
    osc_stop <= 1'b0;
  endtask
endmodule

/* test_rmoi_mode_regs.sv */
// Self-checking bench for the mode register group
module test_rmoi_mode_regs;
  timeunit 1ns;
  timeprecision 100ps;

  logic                         clock;          // 20 MHz clock
  logic                         rst;            // Synchronous reset
  rmoi_pkg::rmoi_cmd_type        cmd;            // Controller command
  rmoi_pkg::rmoi_density_type    density;        // Density shared by both channels
  rmoi_pkg::rmoi_refresh_type    refresh_req;    // Refresh query
  logic                         osc_pin;        // Oscillator input
  logic                         osc_start;      // Start pulse
  logic                         osc_stop;       // Stop pulse
  logic                         cal_active;     // Calibration in progress
  logic                         cal_pattern_bit;// Pattern bit
  logic                         dbi_enable;     // Configured inversion
  logic [7:0]                   read_data_r;    // Read answer
  logic                         read_valid_r;   // Read answer valid
  logic                         refresh_skip_r; // Refresh masked
  logic                         refresh_ack_r;  // Query answered
  logic [1:0][7:0]              bank_mask;      // Bank masks per channel
  logic [1:0][7:0]              seg_mask;       // Segment masks per channel
  rmoi_pkg::rmoi_cal_lane_type   cal_lane;       // Upper byte drive
  logic                         dbi_active_r;   // Inversion in force
  logic                         osc_running_r;  // Counter running
  int                           n_mismatch;     // Mismatches seen
  int                           samples_checked;// Comparisons made

  rmoi_mode_regs #(.CHANNELS(2)) dut_u (.clock(clock), .rst(rst), .cmd(cmd), .density(density),
    .refresh_req(refresh_req), .osc_pin(osc_pin), .osc_start(osc_start), .osc_stop(osc_stop),
    .cal_active(cal_active), .cal_pattern_bit(cal_pattern_bit), .dbi_enable(dbi_enable),
    .read_data_r(read_data_r), .read_valid_r(read_valid_r), .refresh_skip_r(refresh_skip_r),
    .refresh_ack_r(refresh_ack_r), .bank_mask_r(bank_mask), .seg_mask_r(seg_mask),
    .cal_lane_r(cal_lane), .dbi_active_r(dbi_active_r), .osc_running_r(osc_running_r));

  rmoi_ctrl_model ctrl_u (.clock(clock), .density(density), .read_data_r(read_data_r),
    .read_valid_r(read_valid_r), .cmd(cmd), .osc_start(osc_start), .osc_stop(osc_stop));

  // Clock generator
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Single compare point
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Drive calibration inputs and look one cycle later
  task automatic cal_step(input logic act, input logic pat);
    @(posedge clock);
    cal_active <= act;
    cal_pattern_bit <= pat;
    @(posedge clock);
    #1;
  endtask

  // Reset values and read-back of write-only places
  task automatic t_reset;
    logic [7:0] d;
    logic       ok;
    chk("bank mask", bank_mask, 16'h0000);
    chk("seg mask", seg_mask, 16'h0000);
    ctrl_u.mrr(1'b0, 6'h14, d, ok);
    chk("wo read", {ok, d}, 16'h0100);
    ctrl_u.mrr(1'b0, 6'h3F, d, ok);
    chk("unmapped read", {ok, d}, 16'h0100);
    dbi_enable <= 1'b1;
    cal_step(1'b1, 1'b1);
    chk("cal dq reset", cal_lane.dq, 16'h00AA);
    chk("cal dmi", cal_lane.dmi, 16'h0001);
    chk("dbi in cal", dbi_active_r, 16'h0000);
    cal_step(1'b0, 1'b0);
    chk("dbi normal", dbi_active_r, 16'h0001);
    $display("test reset done");
  endtask

  // Per-channel masks
  task automatic t_masks;
    logic [7:0] d;
    logic       ok;
    ctrl_u.mrw(1'b0, 6'h10, 8'hA5);
    ctrl_u.mrw(1'b1, 6'h10, 8'h5A);
    ctrl_u.mrw(1'b0, 6'h11, 8'h81);
    ctrl_u.mrw(1'b1, 6'h11, 8'h18);
    chk("bank mask ch", bank_mask, 16'h5AA5);
    chk("seg mask ch", seg_mask, 16'h1881);
    ctrl_u.mrr(1'b0, 6'h11, d, ok);
    chk("seg wo read", {ok, d}, 16'h0100);
    $display("test masks done");
  endtask

  // One refresh query, answer one cycle later
  task automatic query(input logic ch, input logic [2:0] bank, input logic [16:0] row, input logic exp);
    @(posedge clock);
    refresh_req <= '{valid: 1'b1, channel: ch, bank: bank, row: row};
    @(posedge clock);
    refresh_req <= '0;
    #1;
    chk("refresh skip", {refresh_ack_r, refresh_skip_r}, {15'h0001, exp});
  endtask

  // Segment decode for every density, bank masks per channel
  task automatic t_refresh;
    int top;
    ctrl_u.mrw(1'b0, 6'h11, 8'h08);
    for (int d = 0; d < 7; d++) begin
      density <= rmoi_pkg::rmoi_density_type'(d);
      top = (d == 0) ? 13 : (d < 3) ? 14 : (d < 5) ? 15 : 16;
      query(1'b0, 3'h1, 17'(3) << (top - 2), 1'b1);
      query(1'b0, 3'h1, 17'(2) << (top - 2), 1'b0);
    end
    query(1'b0, 3'h0, 17'h00000, 1'b1);
    query(1'b1, 3'h0, 17'h00000, 1'b0);
    $display("test refresh done");
  endtask

  // Upper lane invert selection
  task automatic t_invert;
    ctrl_u.mrw(1'b0, 6'h14, 8'h15);
    cal_step(1'b1, 1'b0);
    chk("cal dq 0", cal_lane.dq, 16'h0015);
    chk("cal dmi 0", cal_lane.dmi, 16'h0000);
    cal_step(1'b1, 1'b1);
    chk("cal dq 1", cal_lane.dq, 16'h00EA);
    cal_step(1'b0, 1'b0);
    $display("test invert done");
  endtask

  // Oscillator count across both bytes, ignored write, clear on start
  task automatic t_osc;
    logic [15:0] c;
    ctrl_u.osc_cmd(1'b1);
    #13;
    repeat (260) begin
      #200 osc_pin = 1'b1;
      #200 osc_pin = 1'b0;
    end
    repeat (10) @(posedge clock);
    ctrl_u.osc_cmd(1'b0);
    ctrl_u.read_count(c);
    chk("count low", c[7:0], 16'h0004);
    chk("count high", c[15:8], 16'h0001);
    ctrl_u.mrw(1'b0, 6'h12, 8'hFF);
    ctrl_u.mrw(1'b0, 6'h13, 8'hFF);
    ctrl_u.read_count(c);
    chk("count kept", c, 16'h0104);
    ctrl_u.osc_cmd(1'b1);
    ctrl_u.read_count(c);
    chk("count clear", c, 16'h0000);
    chk("running", osc_running_r, 16'h0001);
    ctrl_u.osc_cmd(1'b0);
    $display("test osc done");
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    results();
  end

  // Main sequence
  initial begin
    n_mismatch = 0;
    samples_checked = 0;
    rst = 1'b1;
    density = rmoi_pkg::RMOI_DEN_16G;
    refresh_req = '0;
    osc_pin = 1'b0;
    cal_active = 1'b0;
    cal_pattern_bit = 1'b0;
    dbi_enable = 1'b0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    t_reset();
    t_masks();
    t_refresh();
    t_invert();
    t_osc();
    results();
  end
endmodule
